// ### rtl/dos_pkg.sv
// Purpose: Shared constants for the drive output sequencer.
// Assumes: 200 MHz control clock; delays counted in 10 ms ticks.
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus.
package dos_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ    = 200_000_000;
  localparam int TICK_MS   = 10;
  localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] A_TRIG    = 8'h00;
  localparam logic [7:0] A_OUTFN   = 8'h04;
  localparam logic [7:0] A_TON     = 8'h08;
  localparam logic [7:0] A_TOFF    = 8'h0c;
  localparam logic [7:0] A_BR_CUR  = 8'h10;
  localparam logic [7:0] A_BR_RDLY = 8'h14;
  localparam logic [7:0] A_BR_FWD  = 8'h18;
  localparam logic [7:0] A_BR_REV  = 8'h1c;
  localparam logic [7:0] A_BR_EDLY = 8'h20;
  localparam logic [7:0] A_BR_EFR  = 8'h24;
  localparam logic [7:0] A_AN_SRC  = 8'h28;
  localparam logic [7:0] A_ON_LVL  = 8'h2c;
  localparam logic [7:0] A_OFF_LVL = 8'h30;
  localparam logic [7:0] A_DCB     = 8'h34;
  localparam logic [7:0] A_STATUS  = 8'h38;
  // ------------------------------------------------------------------
  // Function codes and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  FN_TMR_IN  = 8'h26;  // 38
  localparam logic [7:0]  FN_TMR_OUT = 8'h1c;  // 28
  localparam logic [7:0]  FN_BRAKE   = 8'h23;  // 35
  localparam logic [7:0]  FN_ONOFF   = 8'h22;  // 34
  localparam logic [1:0]  SRC_VOLT   = 2'h1;
  localparam logic [1:0]  SRC_CUR    = 2'h2;
  localparam logic [15:0] RST_TON    = 16'h012c; // 3.00 s
  localparam logic [15:0] RST_TOFF   = 16'h0064; // 1.00 s
  localparam logic [11:0] RST_BR_CUR = 12'h1f4;  // 50.0 %
  localparam logic [15:0] RST_BR_DLY = 16'h0064; // 1.00 s
  localparam logic [15:0] RST_BR_RFR = 16'h0064; // 1.00 Hz
  localparam logic [15:0] RST_BR_EFR = 16'h00c8; // 2.00 Hz
  localparam logic [15:0] LVL_MAX    = 16'h2710; // 100.00 %
  localparam logic [15:0] RST_ON     = 16'h2328; // 90.00 %
  localparam logic [15:0] RST_OFF    = 16'h03e8; // 10.00 %
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;
  // ------------------------------------------------------------------
  // Brake sequence states, Gray coded along the run-stop path through DC braking
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    BR_IDLE = 3'h0, BR_ACC = 3'h1, BR_RDLY = 3'h3, BR_RUN = 3'h2,
    BR_DEC  = 3'h6, BR_EDLY = 3'h7, BR_DCB = 3'h5, BR_BLK = 3'h4
  } dos_br_t;
endpackage

// ### rtl/dos_sequencer.sv
// Purpose: Delay timer, brake sequence and analog on/off output control.
// Assumes: Drive core supplies frequency (0.01 Hz), current (0.1 %) and
//          analog levels (0.01 %) synchronous to ref_clk_i.
// Notes:   All delays count 10 ms ticks; TICK_CYCLES shortens them.
//
// How it works
// - Input terminal with function code 38 triggers the delay timer.
// - Relay or output with function code 28 follows the timer result.
// - Timer output rises after trigger stays on for the on-delay.
// - Timer output falls once the off-delay passes after trigger goes off.
// - Active brake control inhibits start DC braking and dwell.
// - Run from stop accelerates to forward or reverse release frequency.
// - Brake released only when current reaches release threshold.
// - After release, frequency held for release delay, then accelerate.
// - Stop decelerates to engage frequency, holds, signals brake engage.
// - Engage delay holds frequency, then frequency is forced to zero.
// - With DC braking configured, brake then block inverter output.
// - Configuration selects the analog source, default the voltage input.
// - On level kept within off..100 %, off level within 0..on.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
module dos_sequencer #(
  parameter int TICK_CYCLES = dos_pkg::TICK_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [6:0]  term_i,
  input  wire logic        run_cmd_i,
  input  wire logic        dir_rev_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [11:0] motor_cur_i,
  input  wire logic        dc_done_i,
  input  wire logic [15:0] an_volt_i,
  input  wire logic [15:0] an_cur_i,
  output logic             relay1_o,
  output logic             q1_o,
  output logic             start_inhibit_o,
  output logic [15:0]      freq_limit_o,
  output logic             freq_limit_en_o,
  output logic             freq_hold_o,
  output logic             freq_zero_o,
  output logic             dc_brake_o,
  output logic             out_block_o
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++)
      if (be[i]) old[i*8 +: 8] = wd[i*8 +: 8];
    return old;
  endfunction

  function automatic logic drive_sel(input logic [7:0] fn,
                                     input logic tmr, input logic brk,
                                     input logic onf);
    return (fn == dos_pkg::FN_TMR_OUT) ? tmr :
           (fn == dos_pkg::FN_BRAKE)   ? brk :
           (fn == dos_pkg::FN_ONOFF)   ? onf : 1'b0;
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [2:0]  trig_idx_reg;
  logic [7:0]  in_fn_reg, relay_fn_reg, q1_fn_reg;
  logic [15:0] ton_reg, toff_reg, br_rdly_reg, br_fwd_reg, br_rev_reg;
  logic [15:0] br_edly_reg, br_efr_reg, on_lvl_reg, off_lvl_reg;
  logic [11:0] br_cur_reg;
  logic [1:0]  an_src_reg, dcb_cfg_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        tmr_out_reg, onoff_reg, relay1_reg, q1_reg;
  logic [15:0] tmr_cnt_reg, dcnt_reg;
  logic [31:0] pre_reg;
  dos_pkg::dos_br_t st_reg, st_next;
  logic        tick, trig, brk_act, brk_rls, wr_go;
  logic [15:0] rel_fr, an_val, wr_on, wr_off;
  logic [31:0] wr_word, rd_word;
  logic [31:0] on_word, off_word, trig_word;

  // ------------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------------
  // Address and data are captured independently; the write commits once
  // both are held and no response is pending.
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dos_pkg::RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_reg)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > dos_pkg::A_DCB ||
                         aw_addr_reg[1:0] != 2'h0) ?
                        dos_pkg::RESP_ERR : dos_pkg::RESP_OK;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  // Level writes are clamped so the on level never sits below the off
  // level nor above full scale; a conflicting write is bent, not refused.
  always_comb
  begin
    on_word   = merge({16'h0, on_lvl_reg}, w_data_reg, w_strb_reg);
    off_word  = merge({16'h0, off_lvl_reg}, w_data_reg, w_strb_reg);
    trig_word = merge({16'h0, in_fn_reg, 5'h0, trig_idx_reg}, w_data_reg,
                      w_strb_reg);
    wr_on  = on_word[15:0];
    wr_off = off_word[15:0];
    if (wr_on > dos_pkg::LVL_MAX) wr_on = dos_pkg::LVL_MAX;
    if (wr_on < off_lvl_reg) wr_on = off_lvl_reg;
    if (wr_off > on_lvl_reg) wr_off = on_lvl_reg;
    wr_word = merge(32'h0, w_data_reg, w_strb_reg);
  end

  // Configuration storage.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      trig_idx_reg <= 3'h0;
      in_fn_reg    <= 8'h00;
      relay_fn_reg <= 8'h00;
      q1_fn_reg    <= 8'h00;
      ton_reg      <= dos_pkg::RST_TON;
      toff_reg     <= dos_pkg::RST_TOFF;
      br_cur_reg   <= dos_pkg::RST_BR_CUR;
      br_rdly_reg  <= dos_pkg::RST_BR_DLY;
      br_fwd_reg   <= dos_pkg::RST_BR_RFR;
      br_rev_reg   <= dos_pkg::RST_BR_RFR;
      br_edly_reg  <= dos_pkg::RST_BR_DLY;
      br_efr_reg   <= dos_pkg::RST_BR_EFR;
      an_src_reg   <= dos_pkg::SRC_VOLT;
      on_lvl_reg   <= dos_pkg::RST_ON;
      off_lvl_reg  <= dos_pkg::RST_OFF;
      dcb_cfg_reg  <= 2'h0;
    end
    else if (wr_go)
      unique case (aw_addr_reg)
        dos_pkg::A_TRIG:
        begin
          trig_idx_reg <= trig_word[2:0];
          in_fn_reg    <= trig_word[15:8];
        end
        dos_pkg::A_OUTFN:
        begin
          relay_fn_reg <= w_strb_reg[0] ? w_data_reg[7:0] : relay_fn_reg;
          q1_fn_reg    <= w_strb_reg[1] ? w_data_reg[15:8] : q1_fn_reg;
        end
        dos_pkg::A_TON:     ton_reg     <= wr_word[15:0] | (ton_reg &
                              ~{{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}});
        dos_pkg::A_TOFF:    toff_reg    <= wr_word[15:0];
        dos_pkg::A_BR_CUR:  br_cur_reg  <= wr_word[11:0];
        dos_pkg::A_BR_RDLY: br_rdly_reg <= wr_word[15:0];
        dos_pkg::A_BR_FWD:  br_fwd_reg  <= wr_word[15:0];
        dos_pkg::A_BR_REV:  br_rev_reg  <= wr_word[15:0];
        dos_pkg::A_BR_EDLY: br_edly_reg <= wr_word[15:0];
        dos_pkg::A_BR_EFR:  br_efr_reg  <= wr_word[15:0];
        dos_pkg::A_AN_SRC:  an_src_reg  <= wr_word[1:0];
        dos_pkg::A_ON_LVL:  on_lvl_reg  <= wr_on;
        dos_pkg::A_OFF_LVL: off_lvl_reg <= wr_off;
        dos_pkg::A_DCB:     dcb_cfg_reg <= wr_word[1:0];
        default: ;
      endcase

  // ------------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h0;
    unique case (s_axi_araddr)
      dos_pkg::A_TRIG:    rd_word = {16'h0, in_fn_reg, 5'h0, trig_idx_reg};
      dos_pkg::A_OUTFN:   rd_word = {16'h0, q1_fn_reg, relay_fn_reg};
      dos_pkg::A_TON:     rd_word = {16'h0, ton_reg};
      dos_pkg::A_TOFF:    rd_word = {16'h0, toff_reg};
      dos_pkg::A_BR_CUR:  rd_word = {20'h0, br_cur_reg};
      dos_pkg::A_BR_RDLY: rd_word = {16'h0, br_rdly_reg};
      dos_pkg::A_BR_FWD:  rd_word = {16'h0, br_fwd_reg};
      dos_pkg::A_BR_REV:  rd_word = {16'h0, br_rev_reg};
      dos_pkg::A_BR_EDLY: rd_word = {16'h0, br_edly_reg};
      dos_pkg::A_BR_EFR:  rd_word = {16'h0, br_efr_reg};
      dos_pkg::A_AN_SRC:  rd_word = {30'h0, an_src_reg};
      dos_pkg::A_ON_LVL:  rd_word = {16'h0, on_lvl_reg};
      dos_pkg::A_OFF_LVL: rd_word = {16'h0, off_lvl_reg};
      dos_pkg::A_DCB:     rd_word = {30'h0, dcb_cfg_reg};
      dos_pkg::A_STATUS:  rd_word = {22'h0, st_reg, brk_act, q1_reg,
                                     relay1_reg, onoff_reg, brk_rls,
                                     tmr_out_reg, trig};
      default: ;
    endcase
  end

  // One read at a time; the address is taken only while no data waits.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= dos_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (s_axi_araddr > dos_pkg::A_STATUS ||
                       s_axi_araddr[1:0] != 2'h0) ?
                      dos_pkg::RESP_ERR : dos_pkg::RESP_OK;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  // ------------------------------------------------------------------
  // Tick prescaler and delay timer
  // ------------------------------------------------------------------
  assign tick = (pre_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i) pre_reg <= 32'h0;
    else         pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;

  assign trig = (in_fn_reg == dos_pkg::FN_TMR_IN) &&
                term_i[trig_idx_reg];

  // One counter serves both delays; it restarts whenever the trigger
  // agrees with the output, so short glitches never leak through.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      tmr_out_reg <= 1'b0;
      tmr_cnt_reg <= 16'h0;
    end
    else if (trig == tmr_out_reg)
      tmr_cnt_reg <= 16'h0;
    else if (trig && tmr_cnt_reg >= ton_reg)
    begin
      tmr_out_reg <= 1'b1;
      tmr_cnt_reg <= 16'h0;
    end
    else if (!trig && tmr_cnt_reg >= toff_reg)
    begin
      tmr_out_reg <= 1'b0;
      tmr_cnt_reg <= 16'h0;
    end
    else if (tick)
      tmr_cnt_reg <= tmr_cnt_reg + 16'h1;

  // ------------------------------------------------------------------
  // Brake sequence
  // ------------------------------------------------------------------
  assign brk_act = (relay_fn_reg == dos_pkg::FN_BRAKE) ||
                   (q1_fn_reg == dos_pkg::FN_BRAKE);
  assign rel_fr  = dir_rev_i ? br_rev_reg : br_fwd_reg;

  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      dos_pkg::BR_IDLE: if (run_cmd_i) st_next = dos_pkg::BR_ACC;
      dos_pkg::BR_ACC:
        if (!run_cmd_i) st_next = dos_pkg::BR_IDLE;
        else if (out_freq_i >= rel_fr && motor_cur_i >= br_cur_reg)
          st_next = dos_pkg::BR_RDLY;
      dos_pkg::BR_RDLY:
        if (!run_cmd_i) st_next = dos_pkg::BR_DEC;
        else if (dcnt_reg >= br_rdly_reg)
          st_next = dos_pkg::BR_RUN;
      dos_pkg::BR_RUN: if (!run_cmd_i) st_next = dos_pkg::BR_DEC;
      dos_pkg::BR_DEC:
        if (run_cmd_i) st_next = dos_pkg::BR_RUN;
        else if (out_freq_i <= br_efr_reg)
          st_next = dos_pkg::BR_EDLY;
      dos_pkg::BR_EDLY:
        if (dcnt_reg >= br_edly_reg)
          st_next = (dcb_cfg_reg == 2'h3) ? dos_pkg::BR_DCB
                                          : dos_pkg::BR_BLK;
      dos_pkg::BR_DCB: if (dc_done_i) st_next = dos_pkg::BR_BLK;
      dos_pkg::BR_BLK: st_next = dos_pkg::BR_IDLE;
    endcase
    if (!brk_act) st_next = dos_pkg::BR_IDLE;
  end

  // The delay count restarts on every state change.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      st_reg   <= dos_pkg::BR_IDLE;
      dcnt_reg <= 16'h0;
    end
    else
    begin
      st_reg   <= st_next;
      dcnt_reg <= (st_next != st_reg) ? 16'h0 :
                  (tick ? dcnt_reg + 16'h1 : dcnt_reg);
    end

  assign brk_rls = (st_reg == dos_pkg::BR_RDLY) ||
                   (st_reg == dos_pkg::BR_RUN) ||
                   (st_reg == dos_pkg::BR_DEC);
  assign start_inhibit_o = brk_act;
  // The limit word is a data output, so it leaves from a flip-flop; it
  // follows a direction change one edge late, on the same edge ACC starts when both change together.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i) freq_limit_o <= dos_pkg::RST_BR_RFR;
    else         freq_limit_o <= rel_fr;
  assign freq_limit_en_o = (st_reg == dos_pkg::BR_ACC);
  assign freq_hold_o     = (st_reg == dos_pkg::BR_RDLY) ||
                           (st_reg == dos_pkg::BR_EDLY);
  assign freq_zero_o     = (st_reg == dos_pkg::BR_DCB) ||
                           (st_reg == dos_pkg::BR_BLK);
  assign dc_brake_o      = (st_reg == dos_pkg::BR_DCB);
  assign out_block_o     = (st_reg == dos_pkg::BR_BLK);

  // ------------------------------------------------------------------
  // Analog on/off control and output terminals
  // ------------------------------------------------------------------
  assign an_val = (an_src_reg == dos_pkg::SRC_VOLT) ? an_volt_i :
                  (an_src_reg == dos_pkg::SRC_CUR)  ? an_cur_i : 16'h0;

  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      onoff_reg  <= 1'b0;
      relay1_reg <= 1'b0;
      q1_reg     <= 1'b0;
    end
    else
    begin
      if (an_val >= on_lvl_reg)       onoff_reg <= 1'b1;
      else if (an_val <= off_lvl_reg) onoff_reg <= 1'b0;
      relay1_reg <= drive_sel(relay_fn_reg, tmr_out_reg, brk_rls,
                              onoff_reg);
      q1_reg     <= drive_sel(q1_fn_reg, tmr_out_reg, brk_rls, onoff_reg);
    end
  assign relay1_o = relay1_reg;
  assign q1_o     = q1_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rls_cond;
    out_freq_i >= rel_fr && motor_cur_i >= br_cur_reg;
  endsequence
  a_tmr_rise_delay: assert property ($rose(tmr_out_reg) |->
    $past(trig) && $past(tmr_cnt_reg) >= $past(ton_reg))
    else $error("timer output rose early");
  a_tmr_fall_delay: assert property ($fell(tmr_out_reg) |->
    !$past(trig) && $past(tmr_cnt_reg) >= $past(toff_reg))
    else $error("timer output fell early");
  a_tmr_restart: assert property ((!trig && !tmr_out_reg) |=>
    tmr_cnt_reg == 16'h0 && !tmr_out_reg)
    else $error("timer did not restart");
  a_relay_timer: assert property ((relay_fn_reg == dos_pkg::FN_TMR_OUT)
    |=> relay1_o == $past(tmr_out_reg))
    else $error("relay not following timer");
  a_brake_release: assert property ((st_reg == dos_pkg::BR_ACC &&
    run_cmd_i && brk_act) ##0 s_rls_cond |=> brk_rls)
    else $error("brake not released");
  a_release_hold: assert property ($rose(brk_rls) |->
    freq_hold_o && $past(st_reg == dos_pkg::BR_ACC))
    else $error("release without hold");
  a_engage_freq: assert property ((st_reg == dos_pkg::BR_EDLY &&
    $past(st_reg) == dos_pkg::BR_DEC) |->
    $past(out_freq_i) <= $past(br_efr_reg) && !brk_rls && freq_hold_o)
    else $error("engage at wrong frequency");
  a_dc_then_block: assert property ((st_reg == dos_pkg::BR_DCB &&
    dc_done_i && brk_act) |=> out_block_o ##1 !out_block_o)
    else $error("block not after DC braking");
  a_level_order: assert property (on_lvl_reg >= off_lvl_reg &&
    on_lvl_reg <= dos_pkg::LVL_MAX)
    else $error("on/off levels out of order");
  a_onoff_set: assert property ((an_val >= on_lvl_reg) |=>
    onoff_reg)
    else $error("on/off output not set");
endmodule

// ### verification/dos_brake_model.sv
// Purpose: Brake coil model driven by the sequencer's relay terminal.
// Assumes: The brake opens DELAY cycles after its coil is fed.
// Notes:   A cut coil closes it at the next clock edge, like a spring-applied brake.
module dos_brake_model #(
  parameter int DELAY = 4
) (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic coil_i,
  output logic      open_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // Count fed cycles; a slow brake is a large DELAY.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i || !coil_i) cnt <= 0;
    else if (cnt < DELAY) cnt <= cnt + 1;
  end
  assign open_o = (cnt >= DELAY);
endmodule

// ### verification/dos_sequencer_tb.sv
// Purpose: Self-checking bench for the drive output sequencer.
// Assumes: Ticks shortened to 4 cycles; responses held ready always.
// Notes:   Drivers queue expectations; monitors compare on arrival.
module dos_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic        s_axi_arvalid = 0, s_axi_rready = 1, ref_clk_i = 0;
  logic        rstn_i = 0, run_cmd_i = 0, dir_rev_i = 0, dc_done_i = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'hd073;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, relay1_o, q1_o, start_inhibit_o, brk_open;
  logic        freq_limit_en_o, freq_hold_o, freq_zero_o, dc_brake_o;
  logic        out_block_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, b_q[$];
  logic [6:0]  term_i = 0;
  logic [15:0] out_freq_i = 0, an_volt_i = 0, an_cur_i = 0, freq_limit_o;
  logic [11:0] motor_cur_i = 0;
  logic [33:0] r_q[$];
  logic [23:0] m_q[$], v_q[$], obs;
  int          miscompares = 0, tests_run = 0;
  logic [33:0] blk_n = 34'h0;
  // Short ticks keep every delay within a few dozen cycles.
  dos_sequencer #(.TICK_CYCLES(4)) dut (.*);
  dos_brake_model #(.DELAY(4)) model (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .coil_i(relay1_o), .open_o(brk_open));
  assign obs = {freq_limit_o, dc_brake_o, freq_zero_o, freq_hold_o,
                freq_limit_en_o, start_inhibit_o, brk_open, q1_o, relay1_o};
  always #2.5 ref_clk_i = ~ref_clk_i;
  task cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bus responses are judged at the handshake edge itself.
  always @(posedge ref_clk_i)
  begin
    if (s_axi_bvalid && s_axi_bready)
      cmp("bresp", 34'(b_q.pop_front()), 34'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready)
      cmp("rdata", r_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  // Pins are judged at the falling edge, where they have settled.
  always @(negedge ref_clk_i)
    if (m_q.size() > 0)
      cmp("pins", 34'(v_q.pop_front()), 34'(obs & m_q.pop_front()));
  // Count block cycles; each engage sequence must give exactly one.
  always @(negedge ref_clk_i)
    if (out_block_o) blk_n <= blk_n + 34'h1;
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task pk(input logic [23:0] m, input logic [23:0] v);
    m_q.push_back(m);
    v_q.push_back(v);
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 0);
    int n;
    b_q.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) miscompares++;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 0);
    int n;
    r_q.push_back({e, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) miscompares++;
  endtask
  // Random levels strictly between the off and on thresholds.
  task hz(input logic [23:0] v);
    repeat (4)
    begin
      an_volt_i <= 16'h3e9 + 16'(rnd() % 32'h1f3e);
      cyc(2);
      pk(24'h2, v);
    end
  endtask
  task print_verdict();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #20000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    cyc(5);
    rstn_i <= 1'b1;
    cyc(1);
    rd(dos_pkg::A_TON, 32'h12c);
    rd(dos_pkg::A_TOFF, 32'h64);
    rd(dos_pkg::A_BR_FWD, 32'h64);
    rd(dos_pkg::A_BR_CUR, 32'h1f4);
    rd(dos_pkg::A_BR_EFR, 32'hc8);
    rd(dos_pkg::A_AN_SRC, 32'h1);
    rd(dos_pkg::A_OFF_LVL, 32'h3e8);
    rd(8'h3c, 32'h0, dos_pkg::RESP_ERR);
    wr(8'h3c, 32'h1, dos_pkg::RESP_ERR);
    wr(dos_pkg::A_TRIG, 32'h2602);
    wr(dos_pkg::A_OUTFN, 32'h1c);
    wr(dos_pkg::A_TON, 32'h3);
    wr(dos_pkg::A_TOFF, 32'h3);
    term_i <= 7'h7b;
    cyc(25);
    pk(24'h1, 24'h0);
    term_i <= 7'h04;
    cyc(5);
    term_i <= 7'h00;
    cyc(20);
    pk(24'h1, 24'h0);
    term_i <= 7'h04;
    cyc(6);
    pk(24'h1, 24'h0);
    cyc(25);
    pk(24'h1, 24'h1);
    term_i <= 7'h00;
    cyc(4);
    pk(24'h1, 24'h1);
    cyc(25);
    pk(24'h1, 24'h0);
    wr(dos_pkg::A_OUTFN, 32'h2200);
    an_volt_i <= 16'h2328;
    cyc(3);
    pk(24'h2, 24'h2);
    hz(24'h2);
    an_volt_i <= 16'h3e8;
    cyc(3);
    pk(24'h2, 24'h0);
    hz(24'h0);
    wr(dos_pkg::A_AN_SRC, 32'h2);
    an_cur_i <= 16'h251c;
    cyc(3);
    pk(24'h2, 24'h2);
    wr(dos_pkg::A_ON_LVL, 32'h2ee0);
    rd(dos_pkg::A_ON_LVL, 32'h2710);
    wr(dos_pkg::A_OFF_LVL, 32'h4e20);
    rd(dos_pkg::A_OFF_LVL, 32'h2710);
    wr(dos_pkg::A_OUTFN, 32'h23);
    wr(dos_pkg::A_BR_REV, 32'h96);
    wr(dos_pkg::A_BR_RDLY, 32'h3);
    wr(dos_pkg::A_BR_EDLY, 32'h3);
    wr(dos_pkg::A_DCB, 32'h3);
    pk(24'h8, 24'h8);
    run_cmd_i <= 1'b1;
    dir_rev_i <= 1'b1;
    cyc(3);
    pk(24'hffff11, 24'h009610);
    out_freq_i <= 16'h96;
    motor_cur_i <= 12'h1f3;
    cyc(5);
    pk(24'h21, 24'h0);
    motor_cur_i <= 12'h1f4;
    cyc(3);
    pk(24'h21, 24'h21);
    cyc(25);
    pk(24'h25, 24'h05);
    run_cmd_i <= 1'b0;
    out_freq_i <= 16'h12c;
    cyc(4);
    pk(24'h21, 24'h01);
    out_freq_i <= 16'hc8;
    cyc(3);
    pk(24'h65, 24'h20);
    cyc(25);
    pk(24'he0, 24'hc0);
    dc_done_i <= 1'b1;
    cyc(4);
    pk(24'hc0, 24'h0);
    // Second stop without DC braking: engage delay runs straight to block.
    dc_done_i <= 1'b0;
    wr(dos_pkg::A_DCB, 32'h1);
    run_cmd_i <= 1'b1;
    cyc(20);
    run_cmd_i <= 1'b0;
    dir_rev_i <= 1'b0;
    cyc(30);
    pk(24'hffffc0, 24'h006400);
    cyc(3);
    cmp("out_block", 34'h2, blk_n);
    print_verdict();
  end
endmodule
